// ---- core/ppci_pkg.sv ----
// Package for the port pin-change interrupt block: register map, resets,
// bus carrier types.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ppci_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PinCount = 8;
  localparam int AddrWidth = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RiseEdgeEnableOffset = 8'h00;
  localparam logic [7:0] FallEdgeEnableOffset = 8'h04;
  localparam logic [7:0] PinChangeFlagsOffset = 8'h08;
  localparam logic [7:0] CoreIntControlOffset = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions in the core interrupt control register
  // ----------------------------------------------------------------
  localparam int SummaryFlagBit = 0;
  localparam int MasterEnableBit = 3;
  localparam int SleepBit = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RiseEdgeEnableReset = 8'h00;
  localparam logic [7:0] FallEdgeEnableReset = 8'h00;
  localparam logic [7:0] PinChangeFlagsReset = 8'h00;
  localparam logic MasterEnableReset = 1'b0;
  localparam logic SleepReset = 1'b0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [AddrWidth-1:0] adr;
    logic [31:0] dat;
  } ppci_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ppci_wb_rsp_t;

endpackage

// ---- core/ppci_edge_detect.sv ----
// Synchroniser and per-pin edge detector for the watched port.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ns
module ppci_edge_detect (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] riseEnable,
  input wire logic [7:0] fallEnable,
  output logic [7:0] edgeHit
);

  // ----------------------------------------------------------------
  // Synchroniser and history
  // ----------------------------------------------------------------
  logic [7:0] syncA_reg;
  logic [7:0] syncB_reg;
  logic [7:0] prev_reg;
  logic [7:0] syncA_next;
  logic [7:0] syncB_next;
  logic [7:0] prev_next;

  // Two flops before use; prev holds last synchronised sample
  always_comb begin
    syncA_next = pinIn;
    syncB_next = syncA_reg;
    prev_next = syncB_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncA_reg <= 8'h00;
      syncB_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      prev_reg <= prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Edge qualification per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gPin
      // Both enables set gives both polarities
      assign edgeHit[i] =
        (riseEnable[i] & syncB_reg[i] & ~prev_reg[i]) |
        (fallEnable[i] & ~syncB_reg[i] & prev_reg[i]);
    end
  endgenerate

endmodule

// ---- core/ppci_top.sv ----
// Pin-change interrupt block for one 8-pin port, Wishbone register slave.
// Assumes a classic Wishbone master on clk_sys; pins are asynchronous.
`timescale 1ns/1ns

// Notes on behaviour
// - Enabled rising or falling edge sets flag
// - Request raised only while master enable set
// - Flags still set with master enable off
// - Summary flag is OR of pin flags
// - Writing zero clears flag; flags sticky
// - Edge during clearing write keeps flag set
// - Pin change wakes from Sleep if enabled
// - Sleep edge recorded before first instruction
// - Rising enable register, eight bits, reset 0
// - Falling enable register, eight bits, reset 0
// - Both enables detect both edge polarities
// - Flags read/write, hardware set, reset 0
module ppci_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ppci_pkg::ppci_wb_req_t wbReq,
  output ppci_pkg::ppci_wb_rsp_t wbRsp,
  input wire logic [7:0] watchedPort,
  output logic changeIrq,
  output logic wakeRequest
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] riseEdgeEnable_reg;
  logic [7:0] riseEdgeEnable_next;
  logic [7:0] fallEdgeEnable_reg;
  logic [7:0] fallEdgeEnable_next;
  logic [7:0] pinChangeFlags_reg;
  logic [7:0] pinChangeFlags_next;
  logic masterEnable_reg;
  logic masterEnable_next;
  logic sleep_reg;
  logic sleep_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic irq_reg;
  logic irq_next;
  logic wake_reg;
  logic wake_next;
  logic [7:0] edgeHit;
  logic access;
  logic wrByte0;
  logic wrByte1;
  logic summary;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  ppci_edge_detect uEdge (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn(watchedPort),
    .riseEnable(riseEdgeEnable_reg),
    .fallEnable(fallEdgeEnable_reg),
    .edgeHit(edgeHit)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack low on the access edge keeps one answer per request
  assign access = wbReq.cyc & wbReq.stb & ~ack_reg;
  assign wrByte0 = access & wbReq.we & wbReq.sel[0];
  assign wrByte1 = access & wbReq.we & wbReq.sel[1];
  assign summary = |pinChangeFlags_reg;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb begin
    riseEdgeEnable_next = riseEdgeEnable_reg;
    fallEdgeEnable_next = fallEdgeEnable_reg;
    pinChangeFlags_next = pinChangeFlags_reg;
    masterEnable_next = masterEnable_reg;
    sleep_next = sleep_reg;
    if (wrByte0) begin
      unique case (wbReq.adr)
        ppci_pkg::RiseEdgeEnableOffset: begin
          riseEdgeEnable_next = wbReq.dat[7:0];
        end
        ppci_pkg::FallEdgeEnableOffset: begin
          fallEdgeEnable_next = wbReq.dat[7:0];
        end
        ppci_pkg::PinChangeFlagsOffset: begin
          // Plain write: software may clear or set bits
          pinChangeFlags_next = wbReq.dat[7:0];
        end
        ppci_pkg::CoreIntControlOffset: begin
          masterEnable_next = wbReq.dat[ppci_pkg::MasterEnableBit];
        end
        default: begin
        end
      endcase
    end
    if (wrByte1 && wbReq.adr == ppci_pkg::CoreIntControlOffset) begin
      sleep_next = wbReq.dat[ppci_pkg::SleepBit];
    end
    // Hardware set wins over any write in the same cycle
    // Detection ignores the master enable
    pinChangeFlags_next = pinChangeFlags_next | edgeHit;
    // With master enable set, an edge or an already set flag leaves sleep at once
    if (masterEnable_reg && (|edgeHit || summary)) begin
      sleep_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer and outputs
  // ----------------------------------------------------------------
  // Zero wait state: ack one edge after the request is seen
  always_comb begin
    ack_next = access;
    rdData_next = 32'h0000_0000;
    if (access && !wbReq.we) begin
      unique case (wbReq.adr)
        ppci_pkg::RiseEdgeEnableOffset: begin
          rdData_next[7:0] = riseEdgeEnable_reg;
        end
        ppci_pkg::FallEdgeEnableOffset: begin
          rdData_next[7:0] = fallEdgeEnable_reg;
        end
        ppci_pkg::PinChangeFlagsOffset: begin
          rdData_next[7:0] = pinChangeFlags_reg;
        end
        ppci_pkg::CoreIntControlOffset: begin
          rdData_next[ppci_pkg::SummaryFlagBit] = summary;
          rdData_next[ppci_pkg::MasterEnableBit] = masterEnable_reg;
          rdData_next[ppci_pkg::SleepBit] = sleep_reg;
        end
        default: begin
          rdData_next = 32'h0000_0000;
        end
      endcase
    end
    // Level request follows the sticky flags
    irq_next = masterEnable_next & (|pinChangeFlags_next);
    // Wake rises with the edge edge that sets the flag; the flag register
    // updates on that same clock edge, so it is readable at wake
    wake_next = sleep_reg & masterEnable_reg &
      (summary | (|edgeHit));
  end

  // Single register process for all state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      riseEdgeEnable_reg <= ppci_pkg::RiseEdgeEnableReset;
      fallEdgeEnable_reg <= ppci_pkg::FallEdgeEnableReset;
      pinChangeFlags_reg <= ppci_pkg::PinChangeFlagsReset;
      masterEnable_reg <= ppci_pkg::MasterEnableReset;
      sleep_reg <= ppci_pkg::SleepReset;
      ack_reg <= 1'b0;
      rdData_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      riseEdgeEnable_reg <= riseEdgeEnable_next;
      fallEdgeEnable_reg <= fallEdgeEnable_next;
      pinChangeFlags_reg <= pinChangeFlags_next;
      masterEnable_reg <= masterEnable_next;
      sleep_reg <= sleep_next;
      ack_reg <= ack_next;
      rdData_reg <= rdData_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  assign wbRsp.ack = ack_reg;
  assign wbRsp.dat = rdData_reg;
  assign changeIrq = irq_reg;
  assign wakeRequest = wake_reg;

endmodule

// ---- tb/ppci_top_chk.sv ----
// Port checker for the pin-change block, bound to its top module.
// Assumes bus requests are held until ack, as a classic master does.
`timescale 1ns/1ns
module ppci_top_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ppci_pkg::ppci_wb_req_t wbReq,
  input wire ppci_pkg::ppci_wb_rsp_t wbRsp,
  input wire logic changeIrq,
  input wire logic wakeRequest
);
  // ------------------------------------------------------------
  // Register mirrors
  // ------------------------------------------------------------
  logic [7:0] rise_reg;
  logic [7:0] fall_reg;
  logic me_reg;
  logic take;
  logic rd;
  assign take = wbReq.cyc & wbReq.stb & ~wbRsp.ack & wbReq.we & wbReq.sel[0];
  assign rd = wbRsp.ack & ~wbReq.we;
  // Follow lane0 writes, taken at the same edge as the design
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rise_reg <= 8'h00;
      fall_reg <= 8'h00;
      me_reg <= 1'b0;
    end else if (take) begin
      if (wbReq.adr == ppci_pkg::RiseEdgeEnableOffset) rise_reg <= wbReq.dat[7:0];
      if (wbReq.adr == ppci_pkg::FallEdgeEnableOffset) fall_reg <= wbReq.dat[7:0];
      if (wbReq.adr == ppci_pkg::CoreIntControlOffset) me_reg <= wbReq.dat[3];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ack_follows: assert property (
    wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack) else $error("ack late");
  a_ack_pulse: assert property (
    wbRsp.ack |=> !wbRsp.ack) else $error("ack too long");
  a_idle_data: assert property (
    !wbRsp.ack |-> wbRsp.dat == 32'h0) else $error("data while idle");
  a_rise_read: assert property (rd && wbReq.adr == 8'h00
    |-> wbRsp.dat == {24'h0, rise_reg}) else $error("rise enable read");
  a_fall_read: assert property (rd && wbReq.adr == 8'h04
    |-> wbRsp.dat == {24'h0, fall_reg}) else $error("fall enable read");
  a_unmapped_zero: assert property (
    rd && wbReq.adr > 8'h0c |-> wbRsp.dat == 32'h0) else $error("unmapped");
  a_ctrl_enable: assert property (rd && wbReq.adr == 8'h0c
    |-> wbRsp.dat[3] == me_reg) else $error("master enable read");
  a_irq_gated: assert property (
    changeIrq |-> me_reg || $past(me_reg)) else $error("irq not gated");
  a_wake_gated: assert property (
    wakeRequest |-> me_reg || $past(me_reg)) else $error("wake not gated");
endmodule
bind ppci_top ppci_top_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .wbReq(wbReq), .wbRsp(wbRsp), .changeIrq(changeIrq),
  .wakeRequest(wakeRequest));

// ---- tb/ppci_tb_top.sv ----
// Self-checking bench: random enables and pin changes, Wishbone access.
// Assumes the package and top module are compiled first.
`timescale 1ns/1ns
module ppci_tb_top;
  // ------------------------------------------------------------
  // Stimulus and checking
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  ppci_pkg::ppci_wb_req_t wbReq = '0;
  ppci_pkg::ppci_wb_rsp_t wbRsp;
  logic [7:0] watchedPort = 8'h00;
  logic changeIrq;
  logic wakeRequest;
  int mismatches = 0;
  int checksDone = 0;
  int cycles = 0;
  ppci_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .wbReq(wbReq),
    .wbRsp(wbRsp), .watchedPort(watchedPort), .changeIrq(changeIrq),
    .wakeRequest(wakeRequest));
  always #2 clk_sys = ~clk_sys;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far above the roughly 120 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; ack is seen as sampled at the edge
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    wbReq <= '{1'b1, 1'b1, w, 4'h3, a, d};
    @(posedge clk_sys);
    while (wbRsp.ack !== 1'b1) @(posedge clk_sys);
    q = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk_sys);
  endtask
  function automatic logic [7:0] expFlags(input logic [7:0] o, nw, r, f);
    return (~o & nw & r) | (o & ~nw & f);
  endfunction
  initial begin
    logic [31:0] q;
    logic [7:0] r, f, p, e, m;
    int n;
    r = 8'($urandom(32'hc08434c1));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0, q);
      chk(q, 32'h0);
    end
    r = 8'($urandom);
    f = 8'($urandom);
    bus(1'b1, 8'h00, {24'h0, r}, q);
    bus(1'b1, 8'h04, {24'h0, f}, q);
    bus(1'b0, 8'h00, 32'h0, q);
    chk(q, {24'h0, r});
    bus(1'b0, 8'h04, 32'h0, q);
    chk(q, {24'h0, f});
    // Master enable off: flags still gather, request stays low
    e = 8'h00;
    for (int k = 0; k < 4; k++) begin
      p = 8'($urandom);
      e |= expFlags(watchedPort, p, r, f);
      watchedPort <= p;
      repeat (6) @(posedge clk_sys);
      bus(1'b0, 8'h08, 32'h0, q);
      chk(q, {24'h0, e});
      chk({31'h0, changeIrq}, 32'h0);
    end
    bus(1'b0, 8'h0c, 32'h0, q);
    chk(q, {31'h0, |e});
    m = e & 8'h0f;
    bus(1'b1, 8'h08, {24'h0, e & ~m}, q);
    bus(1'b0, 8'h08, 32'h0, q);
    chk(q, {24'h0, e & ~m});
    bus(1'b1, 8'h00, 32'hff, q);
    bus(1'b1, 8'h04, 32'hff, q);
    bus(1'b1, 8'h08, 32'h0, q);
    bus(1'b1, 8'h0c, 32'h8, q);
    for (int k = 0; k < 2; k++) begin
      watchedPort <= watchedPort ^ 8'h01;
      repeat (6) @(posedge clk_sys);
      chk({31'h0, changeIrq}, 32'h1);
      bus(1'b1, 8'h08, 32'h0, q);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, changeIrq}, 32'h0);
    end
    bus(1'b1, 8'h0c, 32'h108, q);
    watchedPort <= watchedPort ^ 8'h02;
    n = 0;
    while (wakeRequest !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 20), 32'h1);
    bus(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h2);
    conclude();
  end
endmodule
